// ===== shared/cemwe_pkg.sv
`default_nettype none
// Shared constants for the card event mask and window enable block
package cemwe_pkg;

    // Register space geometry
    localparam int unsigned     CEMWE_ADDR_W       = 12;     // Byte offset within socket space
    localparam logic [11:0]     CEMWE_SOCKET_BASE  = 12'h800; // Legacy register group base
    localparam logic [11:0]     CEMWE_IDX_INT_CFG  = 12'h005; // Status-change config index
    localparam logic [11:0]     CEMWE_IDX_WIN_EN   = 12'h006; // Window enable index
    localparam logic [11:0]     CEMWE_ADDR_INT_CFG = CEMWE_SOCKET_BASE + CEMWE_IDX_INT_CFG;
    localparam logic [11:0]     CEMWE_ADDR_WIN_EN  = CEMWE_SOCKET_BASE + CEMWE_IDX_WIN_EN;

    // Reset values
    localparam logic [7:0]      CEMWE_INT_CFG_RST  = 8'h00;  // No routing, all masks off
    localparam logic [7:0]      CEMWE_WIN_EN_RST   = 8'h00;  // Every window disabled
    localparam logic [7:0]      CEMWE_UNMAPPED_RD  = 8'h00;  // Answer to unknown offsets
    localparam logic [3:0]      CEMWE_ROUTE_NONE   = 4'h0;   // No legacy routing

    // Field positions in the status-change config register
    localparam int unsigned     CEMWE_NUM_EVENTS   = 4;
    localparam int unsigned     CEMWE_BIT_CD       = 3;      // Card detect change
    localparam int unsigned     CEMWE_BIT_READY    = 2;      // Ready rising edge
    localparam int unsigned     CEMWE_BIT_BWARN    = 1;      // Battery warning
    localparam int unsigned     CEMWE_BIT_BDEAD    = 0;      // Battery dead or status change
    localparam int unsigned     CEMWE_ROUTE_LSB    = 4;      // Route select field, bits 7..4

    // Field positions in the window enable register
    localparam int unsigned     CEMWE_NUM_WINDOWS  = 7;      // Two I/O plus five memory
    localparam int unsigned     CEMWE_BIT_IO_WIN1  = 7;
    localparam int unsigned     CEMWE_BIT_IO_WIN0  = 6;
    localparam int unsigned     CEMWE_BIT_RSVD     = 5;      // Reads zero, write ignored
    localparam int unsigned     CEMWE_BIT_MEM_TOP  = 4;      // Memory windows 4..0
    localparam logic [7:0]      CEMWE_WIN_EN_WMASK = 8'hdf;  // Writable bits

endpackage
`default_nettype wire

// ===== shared/cemwe_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Masks, flags and interrupt between the register bank and the event unit
interface cemwe_evt_if;
    logic [3:0] mask;        // Event masks, bit order as in the config register
    logic [3:0] flag_clear;  // One-cycle clear pulses per flag
    logic [3:0] flag;        // Sticky event flags
    logic       irq;         // Status-change interrupt, registered

    // Register bank side
    modport ctrl (output mask, output flag_clear, input flag, input irq);
    // Event unit side
    modport evt (input mask, input flag_clear, output flag, output irq);
endinterface
`default_nettype wire

// ===== core/cemwe_event_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Card status-change event detection, sticky flags and masked interrupt
module cemwe_event_unit
    import cemwe_pkg::*;
(
    // Clock, reset, enable
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    // Card side levels
    input  wire logic i_card_is_io,
    input  wire logic i_card_detect_line_a,
    input  wire logic i_card_detect_line_b,
    input  wire logic i_card_ready,
    input  wire logic i_battery_warning,
    input  wire logic i_battery_dead,
    input  wire logic i_card_status_change_signal,
    // Masks in, flags and interrupt out
    cemwe_evt_if.evt  evt
);

    // All state of the unit
    typedef struct packed {
        logic       primed;   // Previous levels are valid
        logic       cd_a;     // Last card detect levels
        logic       cd_b;
        logic       ready;
        logic       bwarn;
        logic       bdead;
        logic       sc_pin;
        logic [3:0] flag;     // Sticky flags
        logic       irq;      // Masked interrupt
    } cemwe_evt_state_t;

    cemwe_evt_state_t q;       // Registered state
    cemwe_evt_state_t next_q;  // Next state
    logic [3:0]       set;     // Events seen this cycle

    // Edge detection and flag update
    always_comb begin
        next_q = q;
        set    = 4'h0;
        // First cycle only captures levels, so a reset cannot fake a change
        if (q.primed) begin
            set[CEMWE_BIT_CD]    = (i_card_detect_line_a != q.cd_a) ||
                                   (i_card_detect_line_b != q.cd_b);
            set[CEMWE_BIT_READY] = !i_card_is_io && i_card_ready && !q.ready;
            set[CEMWE_BIT_BWARN] = !i_card_is_io && i_battery_warning && !q.bwarn;
            // I/O cards report through the status-change pin instead
            set[CEMWE_BIT_BDEAD] = i_card_is_io ? (i_card_status_change_signal && !q.sc_pin)
                                                : (i_battery_dead && !q.bdead);
        end
        next_q.primed = 1'b1;
        next_q.cd_a   = i_card_detect_line_a;
        next_q.cd_b   = i_card_detect_line_b;
        next_q.ready  = i_card_ready;
        next_q.bwarn  = i_battery_warning;
        next_q.bdead  = i_battery_dead;
        next_q.sc_pin = i_card_status_change_signal;
        // Set wins over a clear in the same cycle
        next_q.flag   = (q.flag & ~evt.flag_clear) | set;
        next_q.irq    = |(next_q.flag & evt.mask);
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else if (i_ce) begin
            q <= next_q;
        end
    end

    assign evt.flag = q.flag;
    assign evt.irq  = q.irq;

    // A change on card detect line A is latched into its flag
    property p_cd_flag;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && q.primed && (i_card_detect_line_a != q.cd_a)) |=> q.flag[CEMWE_BIT_CD];
    endproperty
    a_cd_flag: assert property (p_cd_flag) else $error("card detect change lost");

    // A memory card ready rise latches its flag
    property p_ready_flag;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && q.primed && !i_card_is_io && i_card_ready && !q.ready)
            |=> q.flag[CEMWE_BIT_READY];
    endproperty
    a_ready_flag: assert property (p_ready_flag) else $error("ready rise lost");

    // Battery warning on a memory card latches its flag
    property p_bwarn_flag;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && q.primed && !i_card_is_io && i_battery_warning && !q.bwarn)
            |=> q.flag[CEMWE_BIT_BWARN];
    endproperty
    a_bwarn_flag: assert property (p_bwarn_flag) else $error("battery warning lost");

    // Status-change pin of an I/O card latches the bit 0 flag
    property p_sc_pin_flag;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && q.primed && i_card_is_io && i_card_status_change_signal && !q.sc_pin)
            |=> q.flag[CEMWE_BIT_BDEAD];
    endproperty
    a_sc_pin_flag: assert property (p_sc_pin_flag) else $error("status change lost");

    // Interrupt follows flags gated by the masks seen one cycle earlier
    property p_irq_masked;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        $past(i_ce) |-> (q.irq == |(q.flag & $past(evt.mask)));
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt mask mismatch");

endmodule
`default_nettype wire

// ===== core/cemwe_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Card detect mask enables card detect interrupts
// - Ready mask enables ready rising-edge interrupts
// - Battery warning mask enables warning interrupts
// - Battery dead mask covers dead or status-change
// - Disabled windows never claim host cycles
// - Window enable register resets to zero
// - Window enable register sits at 806h
// - Bit 7 enables I/O window 1
// - Bit 6 enables I/O window 0
// - Bit 5 reads zero, writes ignored
// - Bits 4..0 enable memory windows 4..0
// - Memory window 0 is bit 0, reset off
// - Upper config nibble selects interrupt routing
// - Card detect flag records either line change
module cemwe_top
    import cemwe_pkg::*;
#(
    parameter int unsigned ADDR_W = CEMWE_ADDR_W   // Register offset width
)(
    // Clock, reset, enable
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_ce,
    // Register port
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    input  wire logic [7:0]        i_reg_wdata,
    output logic      [7:0]        o_reg_rdata,
    // Flag clear from the status register logic
    input  wire logic [3:0]        i_flag_clear,
    // Card side levels
    input  wire logic              i_card_is_io,
    input  wire logic              i_card_detect_line_a,
    input  wire logic              i_card_detect_line_b,
    input  wire logic              i_card_ready,
    input  wire logic              i_battery_warning,
    input  wire logic              i_battery_dead,
    input  wire logic              i_card_status_change_signal,
    // Host cycle decode, one hit per window
    input  wire logic [6:0]        i_cycle_hit,
    output logic      [6:0]        o_cycle_claim,
    // Window enables and routing
    output logic      [1:0]        o_io_window_enable,
    output logic      [4:0]        o_mem_window_enable,
    output logic      [3:0]        o_status_change_route_select,
    // Events and interrupt
    output logic      [3:0]        o_event_flags,
    output logic                   o_status_change_irq
);

    // All state of the register bank
    typedef struct packed {
        logic [7:0] int_cfg;  // Route select and event masks
        logic [7:0] win_en;   // Window enables, bit 5 held at zero
        logic [7:0] rdata;    // Read data, updated on a read
        logic [6:0] claim;    // Per-window claim of the current host cycle
    } cemwe_top_state_t;

    // Reset image of the whole bank
    localparam cemwe_top_state_t RST_STATE = '{
        int_cfg: CEMWE_INT_CFG_RST,
        win_en:  CEMWE_WIN_EN_RST,
        rdata:   CEMWE_UNMAPPED_RD,
        claim:   7'h00
    };

    cemwe_top_state_t q;          // Registered state
    cemwe_top_state_t next_q;     // Next state
    logic             hit_cfg;    // Offset decodes to config register
    logic             hit_win;    // Offset decodes to window enable register
    logic [6:0]       win_vec;    // Enables in window-hit order

    // Event unit link
    cemwe_evt_if evt_link ();

    // Offset decode against the full socket address
    assign hit_cfg = (i_reg_addr == CEMWE_ADDR_INT_CFG[ADDR_W-1:0]);
    assign hit_win = (i_reg_addr == CEMWE_ADDR_WIN_EN[ADDR_W-1:0]);

    // Enables packed as {io1, io0, mem4..mem0}, reserved bit dropped
    assign win_vec = {q.win_en[CEMWE_BIT_IO_WIN1], q.win_en[CEMWE_BIT_IO_WIN0],
                      q.win_en[CEMWE_BIT_MEM_TOP:0]};

    // Register writes, reads and cycle claim
    always_comb begin
        next_q = q;
        // Software writes; a write and a read in one cycle both act
        if (i_reg_wr && hit_cfg) begin
            next_q.int_cfg = i_reg_wdata;
        end
        if (i_reg_wr && hit_win) begin
            // Reserved bit is masked so it can never be set
            next_q.win_en = i_reg_wdata & CEMWE_WIN_EN_WMASK;
        end
        // Reads return the current contents, unknown offsets read zero
        if (i_reg_rd) begin
            if (hit_cfg) begin
                next_q.rdata = q.int_cfg;
            end else if (hit_win) begin
                next_q.rdata = q.win_en & CEMWE_WIN_EN_WMASK;
            end else begin
                next_q.rdata = CEMWE_UNMAPPED_RD;
            end
        end
        // A window claims only when enabled, whatever its address setup
        next_q.claim = i_cycle_hit & win_vec;
    end

    // State register, async reset to the documented defaults
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= RST_STATE;
        end else if (i_ce) begin
            q <= next_q;
        end
    end

    // Masks to the event unit; the route nibble is only exported
    assign evt_link.mask       = q.int_cfg[CEMWE_NUM_EVENTS-1:0];
    assign evt_link.flag_clear = i_ce ? i_flag_clear : 4'h0;

    // Event detection and interrupt
    cemwe_event_unit u_events (
        .i_ref_clk                   (i_ref_clk),
        .i_rst_b                     (i_rst_b),
        .i_ce                        (i_ce),
        .i_card_is_io                (i_card_is_io),
        .i_card_detect_line_a        (i_card_detect_line_a),
        .i_card_detect_line_b        (i_card_detect_line_b),
        .i_card_ready                (i_card_ready),
        .i_battery_warning           (i_battery_warning),
        .i_battery_dead              (i_battery_dead),
        .i_card_status_change_signal (i_card_status_change_signal),
        .evt                         (evt_link)
    );

    // Outputs, all straight from flip-flops
    assign o_reg_rdata                  = q.rdata;
    assign o_cycle_claim                = q.claim;
    assign o_io_window_enable           = {q.win_en[CEMWE_BIT_IO_WIN1],
                                           q.win_en[CEMWE_BIT_IO_WIN0]};
    assign o_mem_window_enable          = q.win_en[CEMWE_BIT_MEM_TOP:0];
    assign o_status_change_route_select = q.int_cfg[7:CEMWE_ROUTE_LSB];
    assign o_event_flags                = evt_link.flag;
    assign o_status_change_irq          = evt_link.irq;

    // A claim is never given through a window that was disabled
    property p_no_claim_disabled;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        $past(i_ce) |-> ((o_cycle_claim & ~$past(win_vec)) == 7'h00);
    endproperty
    a_no_claim_disabled: assert property (p_no_claim_disabled)
        else $error("claim through a disabled window");

    // Enabled memory window 0 with a hit does claim
    property p_claim_enabled;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && (i_cycle_hit[0] && win_vec[0])) |=> o_cycle_claim[0];
    endproperty
    a_claim_enabled: assert property (p_claim_enabled) else $error("enabled hit not claimed");

    // A window enable write with the reserved bit set never stores it
    property p_rsvd_zero;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_reg_wr && hit_win && i_reg_wdata[CEMWE_BIT_RSVD])
            |=> (q.win_en[CEMWE_BIT_RSVD] == 1'b0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit was stored");

    // A write to 806h lands on the matching outputs one cycle later
    property p_win_write;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_reg_wr && hit_win)
            |=> (o_io_window_enable == $past(i_reg_wdata[7:6])) &&
                (o_mem_window_enable == $past(i_reg_wdata[4:0]));
    endproperty
    a_win_write: assert property (p_win_write) else $error("window enable write mismatch");

    // Reading 806h returns stored enables with bit 5 clear
    property p_win_read;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_reg_rd && hit_win && !i_reg_wr)
            |=> (o_reg_rdata == ($past(q.win_en) & CEMWE_WIN_EN_WMASK));
    endproperty
    a_win_read: assert property (p_win_read) else $error("window enable read mismatch");

    // Route nibble follows a config write
    property p_route_write;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_reg_wr && hit_cfg)
            |=> (o_status_change_route_select == $past(i_reg_wdata[7:4]));
    endproperty
    a_route_write: assert property (p_route_write) else $error("route select mismatch");

    // With the card detect mask clear, its flag alone gives no interrupt
    property p_cd_masked;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && !q.int_cfg[CEMWE_BIT_CD] && (o_event_flags == 4'h8) && !i_reg_wr)
            ##1 (o_event_flags == 4'h8) |-> !o_status_change_irq;
    endproperty
    a_cd_masked: assert property (p_cd_masked) else $error("masked card detect raised irq");

    // Reset leaves every window closed and the config register clear
    property p_rst_closed;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !$past(i_rst_b) |-> (q.win_en == CEMWE_WIN_EN_RST) &&
                            (q.int_cfg == CEMWE_INT_CFG_RST);
    endproperty
    a_rst_closed: assert property (p_rst_closed) else $error("reset left state");

    // Window enables change only through a taken write
    property p_win_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !(i_ce && i_reg_wr && hit_win) |=> $stable(q.win_en);
    endproperty
    a_win_hold: assert property (p_win_hold) else $error("window enables drifted");

    // Config register changes only through a taken write
    property p_cfg_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !(i_ce && i_reg_wr && hit_cfg) |=> $stable(q.int_cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config register drifted");

    // Read data stands until the next taken read
    property p_rd_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !(i_ce && i_reg_rd) |=> $stable(o_reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

    // Reading the config register returns its stored value
    property p_cfg_read;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_reg_rd && hit_cfg && !i_reg_wr) |=> (o_reg_rdata == $past(q.int_cfg));
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read mismatch");

    // Offsets outside the two registers read as the fixed pattern
    property p_unmapped_read;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_reg_rd && !hit_cfg && !hit_win) |=> (o_reg_rdata == CEMWE_UNMAPPED_RD);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

    // The low config nibble becomes the event masks
    property p_mask_write;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_reg_wr && hit_cfg) |=> (evt_link.mask == $past(i_reg_wdata[3:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    // I/O window 1 claims its hit when enabled
    property p_claim_io1;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_cycle_hit[6] && o_io_window_enable[1]) |=> o_cycle_claim[6];
    endproperty
    a_claim_io1: assert property (p_claim_io1) else $error("io window 1 not claimed");

    // I/O window 0 claims its hit when enabled
    property p_claim_io0;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_cycle_hit[5] && o_io_window_enable[0]) |=> o_cycle_claim[5];
    endproperty
    a_claim_io0: assert property (p_claim_io0) else $error("io window 0 not claimed");

    // Memory claims are the hits gated by the memory enables
    property p_mem_claim;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_ce |=> (o_cycle_claim[4:0] ==
                  ($past(i_cycle_hit[4:0]) & $past(o_mem_window_enable)));
    endproperty
    a_mem_claim: assert property (p_mem_claim) else $error("memory claim mismatch");

    // Memory window 0 stays silent while its enable is clear
    property p_claim_w0_off;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && i_cycle_hit[0] && !o_mem_window_enable[0]) |=> !o_cycle_claim[0];
    endproperty
    a_claim_w0_off: assert property (p_claim_w0_off) else $error("window 0 claimed");

    // An I/O window 1 claim lasts one cycle per sampled hit, never longer
    property p_claim_once;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_ce && !i_cycle_hit[6]) |=> !o_cycle_claim[6];
    endproperty
    a_claim_once: assert property (p_claim_once) else $error("claim without a hit");

    // The interrupt never stands without a flag behind it
    property p_irq_needs_flag;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        o_status_change_irq |-> (o_event_flags != 4'h0);
    endproperty
    a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("irq with no flag");

endmodule
`default_nettype wire

// ===== verification/cemwe_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// Card in the socket: detect lines, ready, battery and status-change levels
module cemwe_card_model (
    // Card levels toward the controller
    output logic o_is_io,
    output logic o_cd_a,
    output logic o_cd_b,
    output logic o_ready,
    output logic o_bwarn,
    output logic o_bdead,
    output logic o_status_change
);
    // Start as an inserted memory card with nothing pending
    initial begin
        {o_is_io, o_cd_a, o_cd_b, o_ready, o_bwarn, o_bdead, o_status_change} = 7'h00;
    end

    // Memory or I/O personality; swapping it alone is not an event
    task automatic set_kind(input logic io);
        o_is_io = io;
    endtask

    // One event per call: detect lines toggle, the other sources rise
    task automatic kick(input int src);
        case (src)
            0: o_cd_a = ~o_cd_a;
            1: o_cd_b = ~o_cd_b;
            2: o_ready = 1'b1;
            3: o_bwarn = 1'b1;
            4: o_bdead = 1'b1;
            default: o_status_change = 1'b1;
        endcase
    endtask

    // Falling levels must not count, so the bench drops them to prove it
    task automatic settle();
        {o_ready, o_bwarn, o_bdead, o_status_change} = 4'h0;
    endtask
endmodule
`default_nettype wire

// ===== verification/cemwe_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Compare, count, report a mismatch at once
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
// Self-checking bench for the event mask and window enable bank
module cemwe_top_tb;
    import cemwe_pkg::*;
    logic       clk, rst_b, ce, wr, rd;      // Clock, reset and strobes
    logic [11:0] addr;                       // Register offset
    logic [7:0] wdata, rdata, d;             // Write data, read data, scratch
    logic [3:0] clr, flags, route;           // Flag clears, flags, route select
    logic [6:0] hit, claim;                  // Window hits and claims
    logic [1:0] io_en;                       // I/O window enables
    logic [4:0] mem_en;                      // Memory window enables
    logic       irq, is_io, cd_a, cd_b, rdy, bw, bd, sc;  // Interrupt and card levels
    int         failures, check_count, cycles;            // Bench counters

    // Clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    cemwe_card_model card (.o_is_io(is_io), .o_cd_a(cd_a), .o_cd_b(cd_b), .o_ready(rdy),
        .o_bwarn(bw), .o_bdead(bd), .o_status_change(sc));

    cemwe_top dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_flag_clear(clr), .i_card_is_io(is_io), .i_card_detect_line_a(cd_a),
        .i_card_detect_line_b(cd_b), .i_card_ready(rdy), .i_battery_warning(bw),
        .i_battery_dead(bd), .i_card_status_change_signal(sc), .i_cycle_hit(hit),
        .o_cycle_claim(claim), .o_io_window_enable(io_en), .o_mem_window_enable(mem_en),
        .o_status_change_route_select(route), .o_event_flags(flags),
        .o_status_change_irq(irq));

    // Verdict and end of run, the only exit
    task automatic close_out();
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 160 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end

    // One write strobe, held across exactly one taking edge
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // Read: data lands at the taking edge and is sampled at the second falling edge after it
    task automatic reg_rd(input logic [11:0] a, output logic [7:0] v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    // Bounded wait for a flag and interrupt state, then judge it
    task automatic wait_ev(input logic [3:0] f, input logic i);
        for (int n = 0; n < 4 && !(flags === f && irq === i); n++) @(negedge clk);
        `CHK(flags, f)
        `CHK(irq, i)
    endtask

    // Each bit of the window register alone, then all, then one unmapped offset
    task automatic t_windows();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            reg_wr(CEMWE_ADDR_WIN_EN, v);
            `CHK(io_en, v[7:6])
            `CHK(mem_en, v[4:0])
            reg_rd(12'h806, d);
            `CHK(d, v & 8'hdf)
        end
        reg_wr(12'h806, 8'hff);
        reg_wr(12'h807, 8'h00);
        reg_rd(12'h806, d);
        `CHK(d, 8'hdf)
        reg_rd(12'h807, d);
        `CHK(d, 8'h00)
    endtask

    // Hits on every window under three enable patterns
    task automatic t_claim();
        logic [7:0] en [3];
        en = '{8'h41, 8'h00, 8'hff};
        for (int k = 0; k < 3; k++) begin
            reg_wr(12'h806, en[k]);
            hit = 7'h7f;
            @(negedge clk);
            `CHK(claim, {en[k][7:6], en[k][4:0]})
            hit = 7'h00;
            @(negedge clk);
            `CHK(claim, 7'h00)
        end
    endtask

    // Event with mask off stays quiet, mask on raises, clear drops
    task automatic t_event(input int src, input int b);
        logic [3:0] m;
        m = 4'h1 << b;
        card.kick(src);
        wait_ev(m, 1'b0);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        reg_wr(12'h805, {4'h0, m});
        wait_ev(m, 1'b1);
        clr = m;
        @(negedge clk);
        clr = 4'h0;
        wait_ev(4'h0, 1'b0);
        card.settle();
        repeat (3) @(negedge clk);
        `CHK(flags, 4'h0)
        reg_wr(12'h805, 8'h00);
    endtask

    // Route nibble, frozen clock enable, then a reset in mid-run
    task automatic t_route_reset();
        reg_wr(12'h805, 8'ha0);
        `CHK(route, 4'ha)
        ce = 1'b0;
        reg_wr(12'h806, 8'h00);
        ce = 1'b1;
        reg_rd(12'h806, d);
        `CHK(d, 8'hdf)
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        `CHK({io_en, mem_en, route}, 11'h000)
        reg_rd(12'h806, d);
        `CHK(d, 8'h00)
        reg_rd(12'h805, d);
        `CHK(d, 8'h00)
    endtask

    // Main sequence
    initial begin
        {rst_b, wr, rd, clr, hit, addr, wdata} = '0;
        ce = 1'b1;
        failures = 0;
        check_count = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        reg_rd(12'h806, d);
        `CHK(d, 8'h00)
        `CHK(route, 4'h0)
        t_windows();
        t_claim();
        for (int s = 0; s < 5; s++) t_event(s, (s < 2) ? 3 : 4 - s);
        card.set_kind(1'b1);
        card.kick(2);
        repeat (3) @(negedge clk);
        `CHK(flags, 4'h0)
        card.settle();
        t_event(5, 0);
        t_route_reset();
        close_out();
    end
endmodule
`default_nettype wire
